/* isr_pkg.sv */
// Purpose: shared constants and carriers for the instrument status reporting bank
// Assumes: one 25 MHz clock, host access through a plain register select port
// Notes:   register selects are local codes, no bus is implied
package isr_pkg;
    localparam int unsigned WIDE_W = 16;
    localparam int unsigned NARROW_W = 8;
    localparam int unsigned SEL_W = 4;

    // register select codes on the host access port
    localparam logic [3:0] SEL_OP_COND   = 4'h0;
    localparam logic [3:0] SEL_OP_EVT    = 4'h1;
    localparam logic [3:0] SEL_OP_ENB    = 4'h2;
    localparam logic [3:0] SEL_QS_COND   = 4'h3;
    localparam logic [3:0] SEL_QS_EVT    = 4'h4;
    localparam logic [3:0] SEL_QS_ENB    = 4'h5;
    localparam logic [3:0] SEL_STD_COND  = 4'h6;
    localparam logic [3:0] SEL_STD_EVT   = 4'h7;
    localparam logic [3:0] SEL_STD_ENB   = 4'h8;
    localparam logic [3:0] SEL_SRQ_COND  = 4'h9;
    localparam logic [3:0] SEL_SRQ_ENB   = 4'hA;

    // operation condition fields
    localparam int unsigned OP_WAIT_TRIG  = 5;
    localparam int unsigned OP_TRAN_ARMED = 6;
    localparam int unsigned OP_CONST_VOLT = 8;
    localparam int unsigned OP_TRAN_DONE  = 9;
    localparam int unsigned OP_CONST_CURR = 10;
    localparam int unsigned OP_SAMPLE_DONE = 11;
    localparam int unsigned OP_LIST_DONE  = 12;
    localparam int unsigned OP_LIST_RUN   = 14;
    // bits visible in the operation condition read
    localparam logic [15:0] OP_COND_READ_MASK = 16'h4D60;

    // questionable condition fields
    localparam int unsigned QS_VOLT_MODE_ERR = 0;
    localparam int unsigned QS_CURR_MODE_ERR = 1;
    localparam int unsigned QS_THERMAL       = 3;
    localparam int unsigned QS_SLAVE_FAULT   = 6;
    localparam int unsigned QS_VOLT_PROT     = 12;
    localparam int unsigned QS_CURR_PROT     = 13;
    localparam int unsigned QS_SINKING       = 14;

    // status byte fields
    localparam int unsigned SB_QUEUE_NONEMPTY = 3;
    localparam int unsigned SB_MSG_AVAIL      = 4;
    localparam int unsigned SB_STD_SUMMARY    = 5;
    localparam int unsigned SB_SRQ_SUMMARY    = 6;
    localparam int unsigned SB_OP_SUMMARY     = 7;
    localparam int unsigned SB_QS_SUMMARY     = 3;

    localparam logic [15:0] WIDE_RESET   = 16'h0000;
    localparam logic [7:0]  NARROW_RESET = 8'h00;

    // instrument monitor inputs
    typedef struct packed {
        logic trig_enabled;
        logic trig_external;
        logic trig_input;
        logic tran_armed;
        logic const_volt;
        logic const_curr;
        logic tran_done;
        logic sample_done;
        logic list_done;
        logic list_run;
        logic thermal_err;
        logic slave_fault;
        logic volt_prot_err;
        logic curr_prot_err;
        logic ext_ref_en;
        logic sinking;
    } isr_monitor_t;

    // host access request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] sel;
        logic [15:0] wdata;
    } isr_host_req_t;
endpackage

/* isr_event_group.sv */
`timescale 1ns/1ps
// Purpose: one condition/event/enable triplet with a read-to-clear event register
// Assumes: condition sampled every clock
// Notes:   a rising edge in the clear cycle survives the clear
module isr_event_group #(
    parameter int unsigned W = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] cond,
    input  wire logic         evt_clear,
    input  wire logic         enb_wr,
    input  wire logic [W-1:0] enb_wdata,
    output logic      [W-1:0] evt_ff,
    output logic      [W-1:0] enb_ff,
    output logic              summary
);
    logic [W-1:0] cond_prev_ff;
    logic [W-1:0] rise;
    logic [W-1:0] nxt_evt;

    assign rise = cond & ~cond_prev_ff;
    // set beats clear so no edge is lost during a read
    assign nxt_evt = (evt_clear ? '0 : evt_ff) | rise; // R20
    assign summary = |(evt_ff & enb_ff);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cond_prev_ff <= '0;
        end else begin
            cond_prev_ff <= cond;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            evt_ff <= '0;
        end else begin
            evt_ff <= nxt_evt;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            enb_ff <= '0;
        end else if (enb_wr) begin
            enb_ff <= enb_wdata;
        end
    end
endmodule

/* isr_wait_trig.sv */
`timescale 1ns/1ps
// Purpose: waiting-for-trigger flag generation
// Assumes: trigger input synchronous to ref_clk
// Notes:   a low external trigger keeps the flag up until the input is high again
module isr_wait_trig (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic trig_enabled,
    input  wire logic trig_external,
    input  wire logic trig_input,
    output logic      waiting_trigger_flag
);
    logic hold_ff;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_ff <= 1'b0;
        end else if (trig_external && !trig_input && (trig_enabled || hold_ff)) begin
            hold_ff <= 1'b1;
        end else if (trig_input || !trig_external) begin
            hold_ff <= 1'b0;
        end
    end

    assign waiting_trigger_flag = trig_enabled | hold_ff;
endmodule

/* isr_status_bank.sv */
`timescale 1ns/1ps
// Purpose: status reporting bank with operation, questionable, standard event and
//          service request groups, status byte and service request line
// Assumes: host reads and writes through a select port, one cycle per access
// Notes:   read data is registered, valid one cycle after the read strobe

// Summary of operation
// R1 - four condition registers, 16 and 8 bits
// R2 - each but the service request register has event and enable companions
// R3 - rising condition bit sets event bit
// R4 - event read returns then clears all
// R5 - enabled questionable event sets status bit 3
// R6 - masked service request bits form bit 6
// R7 - bit 6 drives service request line
// R8 - queue not empty bit 3, message bit 4
// R9 - clean command decode keeps bit 3 zero
// R10 - unused operation bits read zero
// R11 - wait-trigger bit, held while trigger low
// R12 - operation live condition bit assignments
// R13 - transient and list complete event only
// R14 - mode errors on questionable bits 0, 1
// R15 - thermal bit 3, slave fault bit 6
// R16 - protection bits 12, 13; external sets both
// R17 - questionable bit 14 while sinking
// R18 - unused questionable bits read zero
// R19 - status bit 4 shows response data
// R20 - new edge survives a clearing read
module isr_status_bank (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire isr_pkg::isr_monitor_t mon,
    input  wire isr_pkg::isr_host_req_t host_req,
    input  wire logic [7:0]            std_event_cond,
    input  wire logic                  error_queue_nonempty,
    input  wire logic                  output_msg_waiting,
    output logic [15:0]                rdata_ff,
    output logic                       rvalid_ff,
    output logic [7:0]                 status_byte,
    output logic                       srq_line
);
    logic [15:0] op_cond;
    logic [15:0] op_evt_src;
    logic [15:0] qs_cond;
    logic [15:0] op_evt;
    logic [15:0] op_enb;
    logic [15:0] qs_evt;
    logic [15:0] qs_enb;
    logic [7:0]  std_evt;
    logic [7:0]  std_enb;
    logic [7:0]  srq_enb_ff;
    logic        op_sum;
    logic        qs_sum;
    logic        std_sum;
    logic        wait_flag;
    logic        prot_any;
    logic [7:0]  srq_low;
    logic [15:0] nxt_rdata;

    function automatic logic is_rd(input isr_pkg::isr_host_req_t r, input logic [3:0] s);
        is_rd = r.rd && (r.sel == s);
    endfunction

    function automatic logic is_wr(input isr_pkg::isr_host_req_t r, input logic [3:0] s);
        is_wr = r.wr && (r.sel == s);
    endfunction

    isr_wait_trig u_wait (
        .ref_clk              (ref_clk),
        .reset_n              (reset_n),
        .trig_enabled         (mon.trig_enabled),
        .trig_external        (mon.trig_external),
        .trig_input           (mon.trig_input),
        .waiting_trigger_flag (wait_flag)
    );

    // operation group: live bits plus event-only completions
    always_comb begin
        op_evt_src = 16'h0000;                                          // R10
        op_evt_src[isr_pkg::OP_WAIT_TRIG]   = wait_flag;                // R11
        op_evt_src[isr_pkg::OP_TRAN_ARMED]  = mon.tran_armed;           // R12
        op_evt_src[isr_pkg::OP_CONST_VOLT]  = mon.const_volt;           // R12
        op_evt_src[isr_pkg::OP_CONST_CURR]  = mon.const_curr;           // R12
        op_evt_src[isr_pkg::OP_SAMPLE_DONE] = mon.sample_done;          // R12
        op_evt_src[isr_pkg::OP_LIST_RUN]    = mon.list_run;             // R12
        op_evt_src[isr_pkg::OP_TRAN_DONE]   = mon.tran_done;            // R13
        op_evt_src[isr_pkg::OP_LIST_DONE]   = mon.list_done;            // R13
    end

    // transient and list completion bits are masked from the readable condition
    assign op_cond = op_evt_src & isr_pkg::OP_COND_READ_MASK;          // R13

    // external reference widens any protection trip to both bits
    assign prot_any = mon.ext_ref_en & (mon.volt_prot_err | mon.curr_prot_err);

    always_comb begin
        qs_cond = 16'h0000;                                             // R18
        qs_cond[isr_pkg::QS_VOLT_MODE_ERR] = mon.const_curr;            // R14
        qs_cond[isr_pkg::QS_CURR_MODE_ERR] = mon.const_volt;            // R14
        qs_cond[isr_pkg::QS_THERMAL]       = mon.thermal_err;           // R15
        qs_cond[isr_pkg::QS_SLAVE_FAULT]   = mon.slave_fault;           // R15
        qs_cond[isr_pkg::QS_VOLT_PROT]     = mon.volt_prot_err | prot_any; // R16
        qs_cond[isr_pkg::QS_CURR_PROT]     = mon.curr_prot_err | prot_any; // R16
        qs_cond[isr_pkg::QS_SINKING]       = mon.sinking;               // R17
    end

    isr_event_group #(.W(16)) u_op (                                    // R2
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .cond      (op_evt_src),                                        // R3
        .evt_clear (is_rd(host_req, isr_pkg::SEL_OP_EVT)),              // R4
        .enb_wr    (is_wr(host_req, isr_pkg::SEL_OP_ENB)),
        .enb_wdata (host_req.wdata),
        .evt_ff    (op_evt),
        .enb_ff    (op_enb),
        .summary   (op_sum)
    );

    isr_event_group #(.W(16)) u_qs (                                    // R2
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .cond      (qs_cond),                                           // R3
        .evt_clear (is_rd(host_req, isr_pkg::SEL_QS_EVT)),              // R4
        .enb_wr    (is_wr(host_req, isr_pkg::SEL_QS_ENB)),
        .enb_wdata (host_req.wdata),
        .evt_ff    (qs_evt),
        .enb_ff    (qs_enb),
        .summary   (qs_sum)
    );

    isr_event_group #(.W(8)) u_std (                                    // R1
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .cond      (std_event_cond),
        .evt_clear (is_rd(host_req, isr_pkg::SEL_STD_EVT)),             // R20
        .enb_wr    (is_wr(host_req, isr_pkg::SEL_STD_ENB)),
        .enb_wdata (host_req.wdata[7:0]),
        .evt_ff    (std_evt),
        .enb_ff    (std_enb),
        .summary   (std_sum)
    );

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            srq_enb_ff <= isr_pkg::NARROW_RESET;
        end else if (is_wr(host_req, isr_pkg::SEL_SRQ_ENB)) begin
            srq_enb_ff <= host_req.wdata[7:0];
        end
    end

    // service request register, bit 6 excluded from its own summary
    always_comb begin
        srq_low = 8'h00;
        // questionable summary shares bit 3 with the queue flag
        srq_low[isr_pkg::SB_QUEUE_NONEMPTY] = error_queue_nonempty | qs_sum; // R5 R8 R9
        srq_low[isr_pkg::SB_MSG_AVAIL]      = output_msg_waiting;       // R8 R19
        srq_low[isr_pkg::SB_STD_SUMMARY]    = std_sum;
        srq_low[isr_pkg::SB_OP_SUMMARY]     = op_sum;
        status_byte = srq_low;
        status_byte[isr_pkg::SB_SRQ_SUMMARY] = |(srq_low & srq_enb_ff); // R6
    end

    assign srq_line = status_byte[isr_pkg::SB_SRQ_SUMMARY];            // R7

    always_comb begin
        case (host_req.sel)
            isr_pkg::SEL_OP_COND:   nxt_rdata = op_cond;                // R10
            isr_pkg::SEL_OP_EVT:    nxt_rdata = op_evt;
            isr_pkg::SEL_OP_ENB:    nxt_rdata = op_enb;
            isr_pkg::SEL_QS_COND:   nxt_rdata = qs_cond;                // R18
            isr_pkg::SEL_QS_EVT:    nxt_rdata = qs_evt;
            isr_pkg::SEL_QS_ENB:    nxt_rdata = qs_enb;
            isr_pkg::SEL_STD_COND:  nxt_rdata = {8'h00, std_event_cond};
            isr_pkg::SEL_STD_EVT:   nxt_rdata = {8'h00, std_evt};
            isr_pkg::SEL_STD_ENB:   nxt_rdata = {8'h00, std_enb};
            isr_pkg::SEL_SRQ_COND:  nxt_rdata = {8'h00, status_byte};
            isr_pkg::SEL_SRQ_ENB:   nxt_rdata = {8'h00, srq_enb_ff};
            default:                nxt_rdata = 16'h0000;
        endcase
    end

    // read data captures the event value before the clear lands
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff  <= isr_pkg::WIDE_RESET;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= host_req.rd;
            if (host_req.rd) begin
                rdata_ff <= nxt_rdata;                                  // R4
            end
        end
    end
endmodule

/* isr_status_bank_asserts.sv */
// Purpose: port-level checks for the status reporting bank
// Assumes: one clock domain, reset low disables all checks
// Notes:   bound into every isr_status_bank instance
`timescale 1ns/1ps
module isr_chk (
    input wire logic                   ref_clk,
    input wire logic                   reset_n,
    input wire isr_pkg::isr_monitor_t  mon,
    input wire isr_pkg::isr_host_req_t host_req,
    input wire logic [7:0]             std_event_cond,
    input wire logic                   error_queue_nonempty,
    input wire logic                   output_msg_waiting,
    input wire logic [15:0]            rdata_ff,
    input wire logic                   rvalid_ff,
    input wire logic [7:0]             status_byte,
    input wire logic                   srq_line
);
    logic rq_qe;
    logic rq_oc;
    logic rq_qc;
    assign rq_qe = host_req.rd && host_req.sel == isr_pkg::SEL_QS_EVT;
    assign rq_oc = host_req.rd && host_req.sel == isr_pkg::SEL_OP_COND;
    assign rq_qc = host_req.rd && host_req.sel == isr_pkg::SEL_QS_COND;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    srq_follow_a: assert property (srq_line == status_byte[6])
        else $error("srq line differs from status bit 6");
    rvalid_pulse_a: assert property (rvalid_ff == $past(host_req.rd))
        else $error("read valid not one cycle after read");
    msg_bit_a: assert property (status_byte[4] == output_msg_waiting)
        else $error("status bit 4 differs from message waiting");
    queue_bit_a: assert property (error_queue_nonempty |-> status_byte[3])
        else $error("queue not empty but status bit 3 low");
    operation_group_unused_a: assert property (rq_oc |=> (rdata_ff & 16'hB29F) == 16'h0000)
        else $error("unused operation bit read as one");
    questionable_group_unused_a: assert property (rq_qc |=> (rdata_ff & 16'h8FB4) == 16'h0000)
        else $error("unused questionable bit read as one");
    evt_rise_a: assert property ($rose(mon.thermal_err) ##2 rq_qe |=> rdata_ff[3])
        else $error("thermal rise not captured in event");
    evt_clear_a: assert property ($stable(mon) ##1 (rq_qe && $stable(mon)) ##1 rq_qe
        |=> rdata_ff == 16'h0000)
        else $error("event read did not clear");
    // the rise lands in the clearing read's own cycle; the next read must still see it
    rise_keep_a: assert property (($rose(mon.sinking) && rq_qe) ##1 rq_qe |=> rdata_ff[14])
        else $error("rise lost in clearing read");
endmodule
bind isr_status_bank isr_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .mon(mon),
    .host_req(host_req), .std_event_cond(std_event_cond),
    .error_queue_nonempty(error_queue_nonempty), .output_msg_waiting(output_msg_waiting),
    .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff), .status_byte(status_byte),
    .srq_line(srq_line));

/* isr_host.sv */
// Purpose: host controller model reaching the bank through the select port
// Assumes: requests change at the falling edge, one per cycle
// Notes:   idle select and data show inverted values, so stale values never match
`timescale 1ns/1ps
module isr_host (
    input  wire logic                  ref_clk,
    input  wire logic [15:0]           rdata_ff,
    input  wire logic                  rvalid_ff,
    output isr_pkg::isr_host_req_t     host_req
);
    initial host_req = '0;
    // n back-to-back accesses; read data of access i lands in d[16*i +: 16]
    task automatic xfer(input logic w, input logic [3:0] s, input logic [15:0] wd,
                        input int n, output logic [31:0] d);
        d = '0;
        @(negedge ref_clk);
        host_req <= {~w, w, s, wd};
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            if (!w) d[16*i +: 16] = rvalid_ff ? rdata_ff : 16'hxxxx;
        end
        host_req <= {2'b00, ~s, ~wd};
    endtask
endmodule

/* isr_status_bank_tb.sv */
// Purpose: self-checking bench for the status reporting bank
// Assumes: host model drives the select port, bench drives monitors
// Notes:   event capture is at the same edge that first samples the rise
`timescale 1ns/1ps
module isr_status_bank_tb;
    logic                   ref_clk;
    logic                   reset_n;
    isr_pkg::isr_monitor_t  mon;
    isr_pkg::isr_host_req_t host_req;
    logic [7:0]             std_event_cond;
    logic [7:0]             status_byte;
    logic                   error_queue_nonempty;
    logic                   output_msg_waiting;
    logic                   rvalid_ff;
    logic                   srq_line;
    logic [15:0]            rdata_ff;
    logic [31:0]            d;
    int                     n_mismatch;
    int                     num_checks;
    isr_status_bank u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .mon(mon),
        .host_req(host_req), .std_event_cond(std_event_cond),
        .error_queue_nonempty(error_queue_nonempty),
        .output_msg_waiting(output_msg_waiting), .rdata_ff(rdata_ff),
        .rvalid_ff(rvalid_ff), .status_byte(status_byte), .srq_line(srq_line));
    isr_host u_host (.ref_clk(ref_clk), .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff),
        .host_req(host_req));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [3:0] s, input int n);
        u_host.xfer(1'b0, s, 16'h0000, n, d);
    endtask
    task automatic wr(input logic [3:0] s, input logic [15:0] v);
        u_host.xfer(1'b1, s, v, 1, d);
    endtask
    task automatic results();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic t_regs();
        logic [3:0] s [5] = '{4'h2, 4'h5, 4'h8, 4'hA, 4'hB};
        for (int i = 0; i < 5; i++) begin
            rd(s[i], 1);
            chk(d[15:0], 16'h0000);
            wr(s[i], 16'hA5A5);
            rd(s[i], 1);
            chk(d[15:0], i < 2 ? 16'hA5A5 : i < 4 ? 16'h00A5 : 16'h0000);
            wr(s[i], 16'h0000);
        end
        wr(isr_pkg::SEL_QS_COND, 16'hFFFF);
        rd(isr_pkg::SEL_QS_COND, 1);
        chk(d[15:0], 16'h0000);
    endtask
    task automatic t_operation_group();
        wr(isr_pkg::SEL_OP_ENB, 16'h4000);
        // armed, both modes, all done flags, list running
        mon = isr_pkg::isr_monitor_t'(16'h1FC0);
        rd(isr_pkg::SEL_OP_COND, 1);
        chk(d[15:0], 16'h4D40);
        chk({15'h0, status_byte[7]}, 16'h0001);
        rd(isr_pkg::SEL_OP_EVT, 2);
        chk(d[15:0], 16'h5F40);
        chk(d[31:16], 16'h0000);
        chk({15'h0, status_byte[7]}, 16'h0000);
        mon = '0;
    endtask
    task automatic t_wait();
        mon.trig_enabled = 1'b1;
        rd(isr_pkg::SEL_OP_COND, 1);
        chk(d[15:0], 16'h0020);
        mon.trig_external = 1'b1;
        repeat (2) @(negedge ref_clk);
        mon.trig_enabled = 1'b0;
        rd(isr_pkg::SEL_OP_COND, 1);
        chk(d[15:0], 16'h0020);
        mon.trig_input = 1'b1;
        rd(isr_pkg::SEL_OP_COND, 1);
        chk(d[15:0], 16'h0000);
        mon = '0;
    endtask
    task automatic t_questionable_group();
        logic [15:0] mv [9] = '{16'h0400, 16'h0800, 16'h0020, 16'h0010, 16'h0008,
                                16'h0004, 16'h0001, 16'h000A, 16'h0006};
        logic [15:0] ex [9] = '{16'h0001, 16'h0002, 16'h0008, 16'h0040, 16'h1000,
                                16'h2000, 16'h4000, 16'h3000, 16'h3000};
        rd(isr_pkg::SEL_QS_EVT, 1);
        for (int i = 0; i < 9; i++) begin
            @(negedge ref_clk) mon = '0;
            @(negedge ref_clk) mon = isr_pkg::isr_monitor_t'(mv[i]);
            @(negedge ref_clk);
            rd(isr_pkg::SEL_QS_EVT, 1);
            chk(d[15:0], ex[i]);
            rd(isr_pkg::SEL_QS_COND, 1);
            chk(d[15:0], ex[i]);
        end
    endtask
    task automatic t_b2b();
        @(negedge ref_clk) mon = '0;
        rd(isr_pkg::SEL_QS_EVT, 1);
        // sinking rises at the very edge that takes the first clearing read
        fork
            rd(isr_pkg::SEL_QS_EVT, 2);
            begin
                @(negedge ref_clk) mon.sinking = 1'b1;
            end
        join
        chk(d[15:0], 16'h0000);
        chk(d[31:16], 16'h4000);
        rd(isr_pkg::SEL_QS_EVT, 2);
        chk(d[31:16], 16'h0000);
        mon = '0;
    endtask
    task automatic t_srq();
        wr(isr_pkg::SEL_QS_ENB, 16'h0001);
        rd(isr_pkg::SEL_QS_EVT, 1);
        rd(isr_pkg::SEL_SRQ_COND, 1);
        chk(d[15:0] & 16'h0008, 16'h0000);
        mon.const_curr = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk({15'h0, status_byte[3]}, 16'h0001);
        rd(isr_pkg::SEL_QS_EVT, 1);
        chk({15'h0, status_byte[3]}, 16'h0000);
        wr(isr_pkg::SEL_SRQ_ENB, 16'h0010);
        output_msg_waiting = 1'b1;
        @(negedge ref_clk);
        chk({13'h0, status_byte[6], srq_line, status_byte[4]}, 16'h0007);
        output_msg_waiting = 1'b0;
        error_queue_nonempty = 1'b1;
        @(negedge ref_clk);
        chk({13'h0, status_byte[6], srq_line, status_byte[3]}, 16'h0001);
        wr(isr_pkg::SEL_SRQ_ENB, 16'h0008);
        chk({13'h0, status_byte[6], srq_line, status_byte[3]}, 16'h0007);
        wr(isr_pkg::SEL_STD_ENB, 16'h0001);
        std_event_cond = 8'h01;
        repeat (3) @(negedge ref_clk);
        chk({15'h0, status_byte[5]}, 16'h0001);
        rd(isr_pkg::SEL_STD_EVT, 1);
        chk(d[15:0], 16'h0001);
        rd(isr_pkg::SEL_STD_COND, 1);
        chk(d[15:0], 16'h0001);
        error_queue_nonempty = 1'b0;
        @(negedge ref_clk);
        chk({14'h0, status_byte[5], srq_line}, 16'h0000);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // whole run is under two hundred cycles; this bound only catches a hang
    initial begin
        #2_000_000;
        n_mismatch++;
        results();
    end
    initial begin
        mon = '0;
        std_event_cond = 8'h00;
        error_queue_nonempty = 1'b0;
        output_msg_waiting = 1'b0;
        reset_n = 1'b0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) reset_n = 1'b1;
        t_regs();
        t_operation_group();
        t_wait();
        t_questionable_group();
        t_b2b();
        t_srq();
        results();
    end
endmodule
